//--- rsg_pkg.sv
// constants, types and register map of the resonant startup guard
package rsg_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TIME = 8'h04;
	localparam logic [7:0] A_GAIN = 8'h08;
	localparam logic [7:0] A_STAT = 8'h0C;
	localparam logic [7:0] A_IRQS = 8'h10;
	localparam logic [7:0] A_IRQM = 8'h14;
	localparam logic [7:0] A_LAST = 8'h18;

	// ==========================================================
	// field layout
	localparam int C_RUN = 0;
	localparam int T_FIRST_LSB = 0;
	localparam int T_BOOT_LSB = 16;
	localparam int G_QUIET_LSB = 0;
	localparam int G_SHIFT_LSB = 8;
	localparam int G_NOM_LSB = 16;
	localparam int S_SEQ_LSB = 0;
	localparam int S_FCNT_LSB = 8;
	localparam int S_GAIN_LSB = 16;
	localparam int ON_W = 16;
	localparam int FCNT_W = 4;
	localparam int IRQ_W = 3;
	localparam int I_DONE = 0;
	localparam int I_TRIP = 1;
	localparam int I_WDOG = 2;
	localparam int WD_INC_SHIFT = 2;

	// ==========================================================
	// reset values
	localparam logic [31:0] TIME_RST = 32'h0010_0020;
	localparam logic [31:0] GAIN_RST = 32'h0040_0204;
	localparam logic [FCNT_W-1:0] FCNT_MAX = 4'hF;

	// ==========================================================
	// timing
	localparam int CLK_NS = 50;
	localparam int DEAD_NS = 100;
	localparam logic [23:0] DEAD_CYC = 24'((DEAD_NS + CLK_NS - 1) / CLK_NS);

	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// sequencer states
	typedef enum logic [3:0] {
		S_IDLE, S_DISCH, S_BOOT, S_DEAD_H, S_HIGH, S_WAITZ,
		S_DEAD_L, S_LOW, S_DONE, S_OFF, S_PROT
	} rsg_seq_e;

	function automatic logic [31:0] rsg_merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = dat[8*i +: 8];
			end
		end
		return r;
	endfunction : rsg_merge

endpackage : rsg_pkg

//--- rsg_reg_if.sv
// register access carrier between the bus slave and the core
`timescale 1ns/10ps
interface rsg_reg_if;
	logic wrStb;
	logic [7:0] wrAddr;
	logic [31:0] wrData;
	logic [3:0] wrStrb;
	logic wrHit;
	logic [7:0] rdAddr;
	logic [31:0] rdData;
	logic rdHit;
	modport bus(output wrStb, wrAddr, wrData, wrStrb, rdAddr,
		input wrHit, rdData, rdHit);
	modport core(input wrStb, wrAddr, wrData, wrStrb, rdAddr,
		output wrHit, rdData, rdHit);
endinterface : rsg_reg_if

//--- rsg_axil_slave.sv
// axi4-lite slave front end of the register file
`timescale 1ns/10ps
module rsg_axil_slave import rsg_pkg::*; (
	// clock and reset
	input logic mclk,
	input logic rst,
	// write address and data
	input logic awvalid,
	output logic awready,
	input logic [7:0] awaddr,
	input logic wvalid,
	output logic wready,
	input logic [31:0] wdata,
	input logic [3:0] wstrb,
	// write response
	output logic bvalid,
	input logic bready,
	output logic [1:0] bresp,
	// read
	input logic arvalid,
	output logic arready,
	input logic [7:0] araddr,
	output logic rvalid,
	input logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// core side
	rsg_reg_if.bus rb
);
	typedef struct packed {
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
	} rsg_axil_s;

	rsg_axil_s st_ff;
	rsg_axil_s nxt_st;

	// ==========================================================
	// handshakes; a new write waits until the response is taken
	assign awready = !st_ff.awHeld && !st_ff.bValid;
	assign wready = !st_ff.wHeld && !st_ff.bValid;
	assign arready = !st_ff.rValid;
	assign rb.wrStb = st_ff.awHeld && st_ff.wHeld && !st_ff.bValid;
	assign rb.wrAddr = st_ff.awAddr;
	assign rb.wrData = st_ff.wData;
	assign rb.wrStrb = st_ff.wStrb;
	assign rb.rdAddr = araddr;
	assign bvalid = st_ff.bValid;
	assign bresp = st_ff.bResp;
	assign rvalid = st_ff.rValid;
	assign rdata = st_ff.rData;
	assign rresp = st_ff.rResp;

	always_comb begin
		nxt_st = st_ff;
		if (awvalid && awready) begin
			nxt_st.awHeld = 1'b1;
			nxt_st.awAddr = awaddr;
		end
		if (wvalid && wready) begin
			nxt_st.wHeld = 1'b1;
			nxt_st.wData = wdata;
			nxt_st.wStrb = wstrb;
		end
		if (rb.wrStb) begin
			nxt_st.awHeld = 1'b0;
			nxt_st.wHeld = 1'b0;
			nxt_st.bValid = 1'b1;
			nxt_st.bResp = rb.wrHit ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_ff.bValid && bready) begin
			nxt_st.bValid = 1'b0;
		end
		if (arvalid && arready) begin
			nxt_st.rValid = 1'b1;
			nxt_st.rData = rb.rdHit ? rb.rdData : 32'h0000_0000;
			nxt_st.rResp = rb.rdHit ? RESP_OKAY : RESP_SLVERR;
		end
		if (st_ff.rValid && rready) begin
			nxt_st.rValid = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule : rsg_axil_slave

//--- rsg_slope_gain.sv
// short-circuit fault counter and slope compensation gain stepper
`timescale 1ns/10ps
module rsg_slope_gain import rsg_pkg::*; (
	// clock and reset
	input logic mclk,
	input logic rst,
	// events
	input logic faultEv,
	input logic hsPulse,
	// configuration
	input logic [7:0] quietN,
	input logic [2:0] stepShift,
	input logic [7:0] nominal,
	// results
	output logic [7:0] gain,
	output logic [FCNT_W-1:0] faultCnt,
	output logic trip
);
	typedef struct packed {
		logic [7:0] gain;
		logic [FCNT_W-1:0] cnt;
		logic [7:0] quiet;
		logic trip;
	} rsg_gain_s;

	rsg_gain_s st_ff;
	rsg_gain_s nxt_st;
	logic [7:0] step;
	logic [8:0] sum;
	logic [8:0] floorPlus;
	logic [7:0] q;

	assign step = nominal >> stepShift;
	assign gain = st_ff.gain;
	assign faultCnt = st_ff.cnt;
	assign trip = st_ff.trip;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.trip = 1'b0;
		sum = {1'b0, st_ff.gain} + {1'b0, step};
		floorPlus = {1'b0, nominal} + {1'b0, step};
		q = (st_ff.quiet < quietN) ? st_ff.quiet + 8'h01 : st_ff.quiet;
		if (faultEv) begin
			nxt_st.quiet = '0;
			if (st_ff.cnt == FCNT_MAX) begin
				nxt_st.trip = 1'b1;
				nxt_st.cnt = '0;
			end else begin
				nxt_st.cnt = st_ff.cnt + 4'h1;
			end
			nxt_st.gain = sum[8] ? 8'hFF : sum[7:0];
		end else if (hsPulse) begin
			nxt_st.quiet = q;
			if (q >= quietN) begin
				nxt_st.cnt = '0;
				if ({1'b0, st_ff.gain} >= floorPlus) begin
					nxt_st.gain = st_ff.gain - step;
				end else begin
					nxt_st.gain = nominal;
				end
			end
		end
		if (nxt_st.gain < nominal) begin
			nxt_st.gain = nominal;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	chk_fault_count: assert property (
		faultEv && st_ff.cnt != FCNT_MAX |=> st_ff.cnt == $past(st_ff.cnt) + 4'h1)
		else $error("fault counter did not step");
	chk_quiet_clear: assert property (
		hsPulse && !faultEv && quietN != 8'h00 && st_ff.quiet == quietN
		|=> st_ff.cnt == '0)
		else $error("fault counter not cleared after quiet pulses");
	chk_gain_raise: assert property (
		faultEv && st_ff.gain >= nominal && !sum[8] && $stable(nominal)
		|=> st_ff.gain == $past(st_ff.gain) + $past(step))
		else $error("gain did not rise by one step");
	chk_gain_lower: assert property (
		hsPulse && !faultEv && q >= quietN && {1'b0, st_ff.gain} >= floorPlus
		&& $stable(nominal) |=> st_ff.gain == $past(st_ff.gain) - $past(step))
		else $error("gain did not fall by one step");
endmodule : rsg_slope_gain

//--- rsg_startup_guard.sv
// resonant startup sequencer with short-circuit guard, top level
// Function
// - count each current-sense fault event
// - counter overflow stops drive, latched or auto
// - clear counter after quiet high pulses
// - each fault raises slope gain one step
// - after quiet pulses, lower gain per pulse
// - discharge resonant capacitor before each restart
// - open discharge switch when node is low
// - low side alone for bootstrap charge
// - first high pulse fixed, then measure wait
// - long wait gives 3/2 pulse, blank low
// - short wait repeats length, equal low pulse
// - wait zero voltage with no time limit
// - watchdog restarts unfinished sequence after off-time
// - watchdog grows first pulse, capped twice
// - equal-length case completes, go soft-start
// - dead time between the two drivers
// - load soft-start with last high time
`timescale 1ns/10ps
module rsg_startup_guard import rsg_pkg::*; #(
	parameter bit LATCH_PROTECT = 1'b0,
	parameter bit WD_INC_EN = 1'b1,
	parameter logic [23:0] WD_CYCLES = 24'h004E20,
	parameter logic [23:0] AREC_CYCLES = 24'h009C40
) (
	// clock and reset
	input logic mclk,
	input logic rst,
	// axi4-lite register bus
	input logic awvalid,
	output logic awready,
	input logic [7:0] awaddr,
	input logic wvalid,
	output logic wready,
	input logic [31:0] wdata,
	input logic [3:0] wstrb,
	output logic bvalid,
	input logic bready,
	output logic [1:0] bresp,
	input logic arvalid,
	output logic arready,
	input logic [7:0] araddr,
	output logic rvalid,
	input logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// power stage sense
	input logic nodeLow,
	input logic zvsDet,
	input logic csFault,
	input logic extHighPulse,
	// gate drive and discharge switch
	output logic highDrv,
	output logic lowDrv,
	output logic dischargeOn,
	// soft-start hand-off and gain
	output logic ssLoad,
	output logic [ON_W-1:0] ssOnTime,
	output logic [7:0] slopeGain,
	// interrupt
	output logic irq
);
	typedef struct packed {
		rsg_seq_e seq;
		logic [23:0] cnt;
		logic [23:0] wdog;
		logic [ON_W-1:0] meas;
		logic [ON_W-1:0] onLen;
		logic [ON_W-1:0] firstCur;
		logic condB;
		logic hiPrev;
		logic csPrev;
		logic highDrv;
		logic lowDrv;
		logic disch;
		logic ssLoad;
		logic [ON_W-1:0] ssOnTime;
		logic ctrlRun;
		logic [31:0] timeCfg;
		logic [31:0] gainCfg;
		logic [IRQ_W-1:0] irqStat;
		logic [IRQ_W-1:0] irqMask;
		logic irq;
	} rsg_core_s;

	rsg_core_s st_ff;
	rsg_core_s nxt_st;
	rsg_reg_if rb();

	logic faultEv;
	logic hsPulse;
	logic gTrip;
	logic [FCNT_W-1:0] faultCnt;
	logic [23:0] cntInc;
	logic [ON_W-1:0] firstSel;
	logic [ON_W-1:0] bootLen;
	logic [ON_W:0] twiceOn;
	logic [ON_W:0] grownOn;
	logic [ON_W:0] firstCap;
	logic [ON_W:0] firstNext;
	logic active;
	logic [IRQ_W-1:0] irqSet;

	// ==========================================================
	// bus front end and fault/gain unit
	rsg_axil_slave u_bus (
		.mclk(mclk),
		.rst(rst),
		.awvalid(awvalid),
		.awready(awready),
		.awaddr(awaddr),
		.wvalid(wvalid),
		.wready(wready),
		.wdata(wdata),
		.wstrb(wstrb),
		.bvalid(bvalid),
		.bready(bready),
		.bresp(bresp),
		.arvalid(arvalid),
		.arready(arready),
		.araddr(araddr),
		.rvalid(rvalid),
		.rready(rready),
		.rdata(rdata),
		.rresp(rresp),
		.rb(rb.bus)
	);

	// fault is an edge so a long comparator level counts once
	assign faultEv = csFault && !st_ff.csPrev;
	// every rising edge of our own high driver, or one from the run loop
	assign hsPulse = (st_ff.highDrv && !st_ff.hiPrev) || extHighPulse;

	rsg_slope_gain u_gain (
		.mclk(mclk),
		.rst(rst),
		.faultEv(faultEv),
		.hsPulse(hsPulse),
		.quietN(st_ff.gainCfg[G_QUIET_LSB +: 8]),
		.stepShift(st_ff.gainCfg[G_SHIFT_LSB +: 3]),
		.nominal(st_ff.gainCfg[G_NOM_LSB +: 8]),
		.gain(slopeGain),
		.faultCnt(faultCnt),
		.trip(gTrip)
	);

	// ==========================================================
	// register decode
	assign rb.wrHit = rb.wrAddr inside {A_CTRL, A_TIME, A_GAIN, A_STAT,
		A_IRQS, A_IRQM, A_LAST};
	assign rb.rdHit = rb.rdAddr inside {A_CTRL, A_TIME, A_GAIN, A_STAT,
		A_IRQS, A_IRQM, A_LAST};

	always_comb begin
		rb.rdData = 32'h0000_0000;
		unique case (rb.rdAddr)
			A_CTRL: rb.rdData[C_RUN] = st_ff.ctrlRun;
			A_TIME: rb.rdData = st_ff.timeCfg;
			A_GAIN: rb.rdData = st_ff.gainCfg;
			A_STAT: begin
				rb.rdData[S_SEQ_LSB +: 4] = st_ff.seq;
				rb.rdData[S_FCNT_LSB +: FCNT_W] = faultCnt;
				rb.rdData[S_GAIN_LSB +: 8] = slopeGain;
			end
			A_IRQS: rb.rdData[IRQ_W-1:0] = st_ff.irqStat;
			A_IRQM: rb.rdData[IRQ_W-1:0] = st_ff.irqMask;
			A_LAST: rb.rdData[ON_W-1:0] = st_ff.ssOnTime;
			default: rb.rdData = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// sequencer helpers
	assign cntInc = st_ff.cnt + 24'h000001;
	assign firstSel = st_ff.timeCfg[T_FIRST_LSB +: ON_W];
	assign bootLen = st_ff.timeCfg[T_BOOT_LSB +: ON_W];
	assign twiceOn = {st_ff.onLen, 1'b0};
	assign grownOn = {1'b0, st_ff.onLen} + {2'b00, st_ff.onLen[ON_W-1:1]};
	assign firstCap = {firstSel, 1'b0};
	assign firstNext = {1'b0, st_ff.firstCur} + {1'b0, firstSel >> WD_INC_SHIFT};
	assign active = st_ff.seq inside {S_DISCH, S_BOOT, S_DEAD_H, S_HIGH,
		S_WAITZ, S_DEAD_L, S_LOW};

	// ==========================================================
	// sequencer and registers
	always_comb begin
		nxt_st = st_ff;
		irqSet = '0;
		nxt_st.ssLoad = 1'b0;
		nxt_st.csPrev = csFault;
		nxt_st.hiPrev = st_ff.highDrv;
		nxt_st.cnt = cntInc;
		nxt_st.wdog = active ? st_ff.wdog + 24'h000001 : 24'h000000;
		unique case (st_ff.seq)
			S_IDLE: begin
				nxt_st.cnt = '0;
				if (st_ff.ctrlRun) begin
					nxt_st.firstCur = firstSel;
					nxt_st.seq = S_DISCH;
				end
			end
			S_DISCH: begin
				if (nodeLow) begin
					nxt_st.seq = S_BOOT;
					nxt_st.cnt = '0;
				end
			end
			S_BOOT: begin
				if (cntInc >= {8'h00, bootLen}) begin
					nxt_st.seq = S_DEAD_H;
					nxt_st.cnt = '0;
					nxt_st.onLen = st_ff.firstCur;
					nxt_st.condB = 1'b0;
				end
			end
			S_DEAD_H: begin
				if (cntInc >= DEAD_CYC) begin
					nxt_st.seq = S_HIGH;
					nxt_st.cnt = '0;
				end
			end
			S_HIGH: begin
				if (cntInc >= {8'h00, st_ff.onLen}) begin
					nxt_st.cnt = '0;
					nxt_st.meas = '0;
					nxt_st.seq = st_ff.condB ? S_DEAD_L : S_WAITZ;
				end
			end
			S_WAITZ: begin
				// no time limit here; without zvsDet only the watchdog, a trip, clearing run or reset ends it
				if (st_ff.meas != '1) begin
					nxt_st.meas = st_ff.meas + 16'h0001;
				end
				if (zvsDet) begin
					nxt_st.seq = S_HIGH;
					nxt_st.cnt = '0;
					if ({1'b0, st_ff.meas} >= twiceOn) begin
						nxt_st.onLen = grownOn[ON_W] ? '1 : grownOn[ON_W-1:0];
						nxt_st.condB = 1'b0;
					end else begin
						nxt_st.condB = 1'b1;
					end
				end
			end
			S_DEAD_L: begin
				if (cntInc >= DEAD_CYC) begin
					nxt_st.seq = S_LOW;
					nxt_st.cnt = '0;
				end
			end
			S_LOW: begin
				if (cntInc >= {8'h00, st_ff.onLen}) begin
					nxt_st.seq = S_DONE;
					nxt_st.ssLoad = 1'b1;
					nxt_st.ssOnTime = st_ff.onLen;
					irqSet[I_DONE] = 1'b1;
				end
			end
			S_DONE: begin
				nxt_st.cnt = '0;
			end
			S_OFF: begin
				if (cntInc >= WD_CYCLES) begin
					nxt_st.seq = S_DISCH;
					nxt_st.cnt = '0;
				end
			end
			S_PROT: begin
				if (!LATCH_PROTECT && cntInc >= AREC_CYCLES) begin
					nxt_st.seq = S_DISCH;
					nxt_st.cnt = '0;
				end
			end
			default: begin
				nxt_st.seq = S_IDLE;
			end
		endcase
		// watchdog: whole attempt restarts after an equal off-time
		if (active && st_ff.wdog + 24'h000001 >= WD_CYCLES) begin
			nxt_st.seq = S_OFF;
			nxt_st.cnt = '0;
			irqSet[I_WDOG] = 1'b1;
			if (WD_INC_EN) begin
				nxt_st.firstCur = (firstNext > firstCap) ?
					(firstCap[ON_W] ? '1 : firstCap[ON_W-1:0]) :
					firstNext[ON_W-1:0];
			end
		end
		if (gTrip && st_ff.seq != S_IDLE) begin
			nxt_st.seq = S_PROT;
			nxt_st.cnt = '0;
			irqSet[I_TRIP] = 1'b1;
		end
		// a latched trip holds until reset, even with run cleared
		if (!st_ff.ctrlRun && !(LATCH_PROTECT && st_ff.seq == S_PROT)) begin
			nxt_st.seq = S_IDLE;
		end
		// drivers follow the next state so they are glitch free flops
		nxt_st.disch = nxt_st.seq == S_DISCH;
		nxt_st.highDrv = nxt_st.seq == S_HIGH;
		nxt_st.lowDrv = nxt_st.seq inside {S_BOOT, S_LOW};
		// register writes
		if (rb.wrStb) begin
			unique case (rb.wrAddr)
				A_CTRL: begin
					if (rb.wrStrb[0]) begin
						nxt_st.ctrlRun = rb.wrData[C_RUN];
					end
				end
				A_TIME: nxt_st.timeCfg = rsg_merge(st_ff.timeCfg, rb.wrData,
					rb.wrStrb);
				A_GAIN: nxt_st.gainCfg = rsg_merge(st_ff.gainCfg, rb.wrData,
					rb.wrStrb);
				A_IRQS: begin
					if (rb.wrStrb[0]) begin
						nxt_st.irqStat = st_ff.irqStat & ~rb.wrData[IRQ_W-1:0];
					end
				end
				A_IRQM: begin
					if (rb.wrStrb[0]) begin
						nxt_st.irqMask = rb.wrData[IRQ_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		// set wins over a clear in the same cycle
		nxt_st.irqStat = nxt_st.irqStat | irqSet;
		nxt_st.irq = |(nxt_st.irqStat & nxt_st.irqMask);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_ff <= '{seq: S_IDLE, timeCfg: TIME_RST, gainCfg: GAIN_RST,
				default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign highDrv = st_ff.highDrv;
	assign lowDrv = st_ff.lowDrv;
	assign dischargeOn = st_ff.disch;
	assign ssLoad = st_ff.ssLoad;
	assign ssOnTime = st_ff.ssOnTime;
	assign irq = st_ff.irq;

	// ==========================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence lowStaysOff;
		!lowDrv ##1 !lowDrv;
	endsequence
	sequence highStaysOff;
		!highDrv ##1 !highDrv;
	endsequence

	chk_no_overlap: assert property (
		$fell(highDrv) |-> lowStaysOff)
		else $error("low driver on within dead time");
	chk_low_to_high: assert property (
		$fell(lowDrv) |-> highStaysOff)
		else $error("high driver on within dead time");
	chk_trip_stop: assert property (
		gTrip && st_ff.seq != S_IDLE && st_ff.ctrlRun
		|=> !highDrv && !lowDrv && st_ff.seq == S_PROT)
		else $error("overflow did not stop drive");
	chk_disch_open: assert property (
		st_ff.seq == S_DISCH && nodeLow |=> !dischargeOn)
		else $error("discharge switch stayed closed");
	chk_boot_low: assert property (
		st_ff.seq == S_BOOT |-> lowDrv && !highDrv && !dischargeOn)
		else $error("bootstrap phase not low side alone");
	chk_first_blank: assert property (
		st_ff.seq == S_WAITZ |-> !lowDrv && !highDrv)
		else $error("driver active while measuring");
	chk_long_wait: assert property (
		st_ff.seq == S_WAITZ && zvsDet && {1'b0, st_ff.meas} >= twiceOn
		&& st_ff.ctrlRun && !gTrip && !(active && st_ff.wdog + 24'h000001
		>= WD_CYCLES) |=> highDrv && !st_ff.condB
		&& st_ff.onLen >= $past(st_ff.onLen))
		else $error("long wait did not lengthen pulse");
	chk_ss_load: assert property (
		ssLoad |-> ssOnTime == st_ff.onLen && st_ff.seq == S_DONE)
		else $error("soft-start load value wrong");
	chk_wd_off: assert property (
		st_ff.seq == S_OFF |-> !highDrv && !lowDrv && !dischargeOn)
		else $error("drive during watchdog off-time");
	chk_first_cap: assert property (
		$stable(firstSel) |-> {1'b0, st_ff.firstCur} <= firstCap
		|| st_ff.seq == S_IDLE)
		else $error("first pulse above twice its setting");
endmodule : rsg_startup_guard

//--- rsg_stage_model.sv
// power stage model: node discharge and zero-voltage timing
`timescale 1ns/10ps
module rsg_stage_model (
	// clock
	input wire logic mclk,
	// drive from the block
	input wire logic dischargeOn,
	input wire logic highDrv,
	input wire logic lowDrv,
	// knobs set by the bench
	input wire logic [7:0] zDly,
	input wire logic stuck,
	// sense back to the block
	output logic nodeLow,
	output logic zvsDet
);
	int dc = 0;
	int wc = 0;

	// ==========================================================
	// tank behaviour
	always @(posedge mclk) begin
		dc <= dischargeOn ? dc + 1 : 0;
		wc <= (highDrv || lowDrv) ? 0 : wc + 1;
	end
	// current-limited switch needs a few cycles to pull the node down
	assign nodeLow = dischargeOn ? (dc >= 4) : !highDrv;
	// a stuck node never swings, so zero voltage is never reported
	assign zvsDet = !stuck && !highDrv && (wc >= int'(zDly));
endmodule : rsg_stage_model

//--- testbench.sv
// self-checking bench of the resonant startup guard
`timescale 1ns/10ps
module testbench import rsg_pkg::*;;
	localparam logic [23:0] WD = 24'h0007D0;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, stuck = 1'b0;
	logic csFault = 1'b0, extHighPulse = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, zDly = 8'h0A;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, nodeLow, zvsDet;
	logic highDrv, lowDrv, dischargeOn, ssLoad, irq;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	logic [ON_W-1:0] ssOnTime;
	logic [7:0] slopeGain;
	int errors = 0, check_count = 0;
	int hc = 0, lc = 0, gp = 9, n;
	bit ph, pl;
	int hq[$], lq[$];

	always #25 mclk = ~mclk;

	rsg_startup_guard #(.LATCH_PROTECT(1'b0), .WD_CYCLES(WD),
		.AREC_CYCLES(24'h000032)) u_rsg_startup_guard (
		.mclk, .rst, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .rvalid, .rready, .rdata, .rresp, .nodeLow, .zvsDet,
		.csFault, .extHighPulse, .highDrv, .lowDrv, .dischargeOn,
		.ssLoad, .ssOnTime, .slopeGain, .irq);
	rsg_stage_model u_rsg_stage_model (.mclk, .dischargeOn, .highDrv,
		.lowDrv, .zDly, .stuck, .nodeLow, .zvsDet);

	// ==========================================================
	// compare and report
	task automatic fail(input string m);
		errors++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail
	task automatic chk(input logic [31:0] g, e, input string m);
		check_count++;
		if (g !== e) fail(m);
	endtask : chk
	task automatic chkq(input int g[$], e[$], input string m);
		chk(32'(g.size()), 32'(e.size()), m);
		foreach (e[i]) if (i < g.size()) chk(32'(g[i]), 32'(e[i]), m);
	endtask : chkq
	task automatic endt(input string s);
		$display("test %s done, errors %0d", s, errors);
	endtask : endt
	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test

	// ==========================================================
	// bus master
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w;
		aw = 0;
		w = 0;
		@(posedge mclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (!aw && awready) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end while (!(aw && w && bvalid));
		bready <= 1'b0;
		rs = bresp;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		bit ar;
		ar = 0;
		@(posedge mclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (ar && rvalid) break;
			if (arready) begin
				ar = 1;
				arvalid <= 1'b0;
			end
		end while (1);
		rready <= 1'b0;
		rd = rdata;
		rs = rresp;
	endtask : rdr

	// ==========================================================
	// stimulus helpers
	task automatic pls(input bit f, input int k);
		repeat (k) begin
			@(posedge mclk);
			if (f) csFault <= 1'b1;
			else extHighPulse <= 1'b1;
			@(posedge mclk);
			csFault <= 1'b0;
			extHighPulse <= 1'b0;
			repeat (3) @(posedge mclk);
		end
	endtask : pls
	task automatic go;
		wr(A_CTRL, 32'h0);
		// a done flag left from the last run would fake an early irq
		wr(A_IRQS, 32'h7);
		hq.delete();
		lq.delete();
		wr(A_CTRL, 32'h1);
	endtask : go
	// the last pulse lands in the queue one edge after the load strobe
	task automatic waitss(input logic [15:0] e);
		do @(posedge mclk); while (ssLoad !== 1'b1);
		chk({16'h0, ssOnTime}, {16'h0, e}, "hand-off time");
		@(posedge mclk);
	endtask : waitss

	// ==========================================================
	// pulse monitor, dead time and overlap
	always @(posedge mclk) begin
		if (!rst) begin
			if (highDrv === 1'b1) hc++;
			else if (hc > 0) begin
				hq.push_back(hc);
				hc = 0;
			end
			if (lowDrv === 1'b1) lc++;
			else if (lc > 0) begin
				lq.push_back(lc);
				lc = 0;
			end
			if (((highDrv && !ph) || (lowDrv && !pl)) && gp < 2) fail("gap");
			if ((highDrv && lowDrv) || (dischargeOn && (highDrv || lowDrv)))
				fail("overlap");
			gp = (highDrv || lowDrv) ? 0 : gp + 1;
			ph = highDrv;
			pl = lowDrv;
		end
	end

	// ==========================================================
	// tests
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		rdr(A_TIME);
		chk(rd, TIME_RST, "time reset");
		rdr(A_GAIN);
		chk(rd, GAIN_RST, "gain reset");
		rdr(A_STAT);
		chk(rd, 32'h00400000, "status reset");
		rdr(8'h1C);
		chk({rd[31:2], rs}, {30'h0, RESP_SLVERR}, "unmapped read");
		wr(8'h1C, 32'hFFFFFFFF);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped write");
		wr(A_IRQM, 32'h7);
		endt("registers");

		go();
		waitss(16'h0020);
		chkq(hq, '{32, 32}, "high pulses");
		chkq(lq, '{16, 32}, "low pulses");
		rdr(A_STAT);
		chk(rd & 32'hF, 32'h8, "done state");
		chk({31'h0, irq}, 32'h1, "irq set");
		wr(A_IRQS, 32'h1);
		rdr(A_IRQS);
		chk({rd[31:1], irq}, 32'h0, "irq clear");
		chk({31'h0, dischargeOn}, 32'h0, "switch open");
		rdr(A_LAST);
		chk(rd, 32'h20, "last on-time");
		endt("startup");

		zDly <= 8'h50;
		go();
		waitss(16'h0030);
		chkq(hq, '{32, 48, 48}, "long wait");
		chkq(lq, '{16, 48}, "blank low");
		endt("long wait");

		stuck <= 1'b1;
		zDly <= 8'h0A;
		go();
		repeat (1000) @(posedge mclk);
		rdr(A_STAT);
		chk(rd & 32'hF, 32'h5, "still waiting");
		do @(posedge mclk); while (irq !== 1'b1);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (dischargeOn !== 1'b1);
		stuck <= 1'b0;
		chk({31'h0, n >= WD - 4 && n <= WD + 4}, 32'h1, "off time");
		rdr(A_IRQS);
		chk(rd, 32'h4, "watchdog flag");
		wr(A_IRQS, 32'h4);
		waitss(16'h0028);
		chkq(hq, '{32, 40, 40}, "grown pulse");
		endt("watchdog");

		pls(1, 3);
		chk({24'h0, slopeGain}, 32'h70, "gain up");
		rdr(A_STAT);
		chk(rd & 32'hF00, 32'h300, "fault count");
		pls(0, 3);
		chk({24'h0, slopeGain}, 32'h70, "gain held");
		pls(0, 1);
		chk({24'h0, slopeGain}, 32'h60, "gain down");
		rdr(A_STAT);
		chk(rd & 32'hF00, 32'h0, "count cleared");
		pls(0, 1);
		chk({24'h0, slopeGain}, 32'h50, "gain down");
		pls(0, 2);
		chk({24'h0, slopeGain}, 32'h40, "gain floor");
		pls(1, 16);
		hq.delete();
		lq.delete();
		chk({30'h0, highDrv, lowDrv}, 32'h0, "drive stopped");
		rdr(A_STAT);
		chk(rd & 32'hF, 32'hA, "protect state");
		rdr(A_IRQS);
		chk(rd & 32'h2, 32'h2, "trip flag");
		do @(posedge mclk); while (ssLoad !== 1'b1);
		@(posedge mclk);
		chk(32'(hq.size() + lq.size()), 32'h4, "auto restart");
		endt("faults");

		go();
		repeat (30) @(posedge mclk);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		chk({29'h0, highDrv, lowDrv, dischargeOn}, 32'h0, "reset drive");
		rdr(A_STAT);
		chk(rd & 32'hF, 32'h0, "reset state");
		endt("reset");
		stop_test();
	end

	initial begin
		repeat (20000) @(posedge mclk);
		fail("timeout");
		stop_test();
	end
endmodule : testbench
